// ### cep_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: pipeline stages and debug host raising cause lines
module cep_pipe_model (
  input wire logic [20:0] causeVec, // bit n raises cause n
  input wire logic alt, // pick the second source of a shared cause
  output logic masterClearPin,
  output logic powerOnReset,
  output logic singleStepEn,
  output logic extDebugIrqIn,
  output logic debugBreakRequestBit,
  output logic nmiIn,
  output logic [7:0] irqReq,
  output logic [7:0] irqMask,
  output logic instrBreakMatch,
  output logic fetchMisaligned,
  output logic fetchProtected,
  output logic fetchBusErr,
  output logic debugBreakpointInstr,
  output logic systemCallInstr,
  output logic breakInstr,
  output logic reservedInstr,
  output logic copUnusable,
  output logic extUnusable,
  output logic arithOverflow,
  output logic trapTrue,
  output logic loadAddrMatch,
  output logic storeAddrMatch,
  output logic storeDataMatch,
  output logic loadMisaligned,
  output logic loadProtected,
  output logic storeMisaligned,
  output logic storeProtected,
  output logic dataBusErr,
  output logic loadDataMatch
);
  // single-source causes map straight across
  assign {singleStepEn, nmiIn, instrBreakMatch, fetchBusErr, trapTrue,
    arithOverflow, extUnusable, copUnusable, reservedInstr, breakInstr,
    systemCallInstr, debugBreakpointInstr, loadDataMatch,
    dataBusErr} = {causeVec[1], causeVec[3], causeVec[5], causeVec[7],
    causeVec[15:8], causeVec[20:19]};
  // shared causes: alt picks which source raises them
  assign masterClearPin = causeVec[0] & !alt;
  assign powerOnReset = causeVec[0] & alt;
  assign extDebugIrqIn = causeVec[2] & !alt;
  assign debugBreakRequestBit = causeVec[2] & alt;
  assign fetchMisaligned = causeVec[6] & !alt;
  assign fetchProtected = causeVec[6] & alt;
  assign loadAddrMatch = causeVec[16] & !alt;
  // store break only when address and value both match
  assign storeAddrMatch = causeVec[16] & alt;
  assign storeDataMatch = causeVec[16] & alt;
  assign loadMisaligned = causeVec[17] & !alt;
  assign loadProtected = causeVec[17] & alt;
  assign storeMisaligned = causeVec[18] & !alt;
  assign storeProtected = causeVec[18] & alt;
  // masked requests stay pending while bit 4 is low, so masking is exercised then
  assign irqMask = alt ? 8'h80 : 8'h01;
  assign irqReq = causeVec[4] ? irqMask : ~irqMask;
endmodule
`default_nettype wire

// ### cep_pkg.sv
package cep_pkg;
  // cause indices, 0 is highest priority
  localparam int CAUSE_N = 21;
  localparam logic [4:0] C_RESET = 5'h00;
  localparam logic [4:0] C_SSTEP = 5'h01;
  localparam logic [4:0] C_DBGINT = 5'h02;
  localparam logic [4:0] C_NMI = 5'h03;
  localparam logic [4:0] C_IRQ = 5'h04;
  localparam logic [4:0] C_IBRK = 5'h05;
  localparam logic [4:0] C_FADDR = 5'h06;
  localparam logic [4:0] C_FBUS = 5'h07;
  localparam logic [4:0] C_DBGBP = 5'h08;
  localparam logic [4:0] C_SYSTEM_CALL_INSTR = 5'h09;
  localparam logic [4:0] C_BREAK = 5'h0A;
  localparam logic [4:0] C_RESV = 5'h0B;
  localparam logic [4:0] C_COPU = 5'h0C;
  localparam logic [4:0] C_EXTU = 5'h0D;
  localparam logic [4:0] C_OVF = 5'h0E;
  localparam logic [4:0] C_TRAP = 5'h0F;
  localparam logic [4:0] C_DADDR = 5'h10;
  localparam logic [4:0] C_LADDR = 5'h11;
  localparam logic [4:0] C_SADDR = 5'h12;
  localparam logic [4:0] C_DBUS = 5'h13;
  localparam logic [4:0] C_DVAL = 5'h14;
  localparam logic [4:0] C_NONE = 5'h1F;
  // mask of the causes that are debug exceptions
  localparam logic [CAUSE_N-1:0] DEBUG_MASK = 21'h110126;
  typedef enum logic [1:0] {CEP_RUN, CEP_DEBUG, CEP_SLEEP} cep_mode_t;
endpackage

// ### cep_prioritizer.sv
`timescale 1ns/1ns
`default_nettype none
module cep_prioritizer import cep_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic masterClearPin, // active high clear request
  input wire logic powerOnReset,
  input wire logic singleStepEn, // single stepping armed
  input wire logic extDebugIrqIn,
  input wire logic debugBreakRequestBit, // from debug control reg
  input wire logic nmiIn,
  input wire logic [7:0] irqReq,
  input wire logic [7:0] irqMask, // 1 lets the request through
  input wire logic instrBreakMatch,
  input wire logic fetchMisaligned,
  input wire logic fetchProtected,
  input wire logic fetchBusErr,
  input wire logic debugBreakpointInstr,
  input wire logic systemCallInstr,
  input wire logic breakInstr,
  input wire logic reservedInstr,
  input wire logic copUnusable,
  input wire logic extUnusable,
  input wire logic arithOverflow,
  input wire logic trapTrue,
  input wire logic loadAddrMatch,
  input wire logic storeAddrMatch,
  input wire logic storeDataMatch,
  input wire logic loadMisaligned,
  input wire logic loadProtected,
  input wire logic storeMisaligned,
  input wire logic storeProtected,
  input wire logic dataBusErr,
  input wire logic loadDataMatch,
  input wire logic debugReturnInstr,
  input wire logic waitInstr,
  input wire logic wakeEvent, // leaves power down
  output logic excValid, // high in each cycle after one in which any cause is pending
  output logic [4:0] excCode,
  output logic [20:0] excSuppressed, // lower causes dropped
  output logic debugMode,
  output logic powerDown
);

  // whole state in one struct
  typedef struct packed {
    logic valid;
    logic [4:0] code;
    logic [CAUSE_N-1:0] supp;
    cep_mode_t mode;
    logic dbg; // registered debug mode flag, drives the pin directly
    logic pdn; // registered power down flag, drives the pin directly
  } cep_state_t;

  cep_state_t st_reg, st_next;
  logic [CAUSE_N-1:0] cause; // raw pending vector
  logic [4:0] winner;
  logic [CAUSE_N-1:0] winMask;
  logic [CAUSE_N-1:0] clearAbove; // no higher ranked cause pending

  // gather causes, bit index equals rank
  always_comb begin
    cause = '0;
    cause[C_RESET] = masterClearPin | powerOnReset;
    cause[C_SSTEP] = singleStepEn & (st_reg.mode != CEP_DEBUG);
    cause[C_DBGINT] = extDebugIrqIn | debugBreakRequestBit;
    cause[C_NMI] = nmiIn;
    cause[C_IRQ] = |(irqReq & irqMask);
    cause[C_IBRK] = instrBreakMatch;
    cause[C_FADDR] = fetchMisaligned | fetchProtected;
    cause[C_FBUS] = fetchBusErr;
    cause[C_DBGBP] = debugBreakpointInstr;
    cause[C_SYSTEM_CALL_INSTR] = systemCallInstr;
    cause[C_BREAK] = breakInstr;
    cause[C_RESV] = reservedInstr;
    cause[C_COPU] = copUnusable;
    cause[C_EXTU] = extUnusable;
    cause[C_OVF] = arithOverflow;
    cause[C_TRAP] = trapTrue;
    // store break needs address and value together
    cause[C_DADDR] = loadAddrMatch |
      (storeAddrMatch & storeDataMatch);
    cause[C_LADDR] = loadMisaligned | loadProtected;
    cause[C_SADDR] = storeMisaligned | storeProtected;
    cause[C_DBUS] = dataBusErr;
    cause[C_DVAL] = loadDataMatch;
  end

  // fixed priority encoder, lowest index wins
  always_comb begin
    winner = C_NONE;
    for (int i = CAUSE_N - 1; i >= 0; i--) begin
      if (cause[i]) begin
        winner = 5'(i);
      end
    end
  end

  // one-hot of the winner so the rest can be reported
  always_comb begin
    winMask = '0;
    if (winner != C_NONE) begin
      winMask[winner] = 1'b1;
    end
  end

  // ladder of "nothing above me" flags, used only by the checks;
  // built apart from the encoder so a wrong encoder order still shows
  assign clearAbove[0] = 1'b1;
  for (genvar g = 1; g < CAUSE_N; g++) begin : g_clear
    assign clearAbove[g] = clearAbove[g-1] & ~cause[g-1];
  end

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.valid = |cause;
    st_next.code = winner;
    st_next.supp = cause & ~winMask;
    case (st_reg.mode)
      CEP_RUN: begin
        if (winner != C_NONE && DEBUG_MASK[winner]) begin
          st_next.mode = CEP_DEBUG;
        end else if (winner == C_NONE && waitInstr) begin
          st_next.mode = CEP_SLEEP;
        end
      end
      CEP_DEBUG: begin
        // handler runs until the return instruction
        if (debugReturnInstr) begin
          st_next.mode = CEP_RUN;
        end
      end
      CEP_SLEEP: begin
        // any cause or wake event ends power down
        if (winner != C_NONE && DEBUG_MASK[winner]) begin
          st_next.mode = CEP_DEBUG;
        end else if (wakeEvent || winner != C_NONE) begin
          st_next.mode = CEP_RUN;
        end
      end
      default: begin
        st_next.mode = CEP_RUN;
      end
    endcase
    // reset cause always drops back to normal running
    if (cause[C_RESET]) begin
      st_next.mode = CEP_RUN;
    end
    // flags mirror the next mode so the pins leave flops directly
    st_next.dbg = (st_next.mode == CEP_DEBUG);
    st_next.pdn = (st_next.mode == CEP_SLEEP);
  end

  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // nothing reported, normal running, both flags clear
      st_reg <= '{valid: 1'b0, code: C_NONE, supp: '0, mode: CEP_RUN,
        dbg: 1'b0, pdn: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign excValid = st_reg.valid;
  assign excCode = st_reg.code;
  assign excSuppressed = st_reg.supp;
  assign debugMode = st_reg.dbg;
  assign powerDown = st_reg.pdn;

  // checks: a rank wins whenever nothing above it is pending
  AST_RESET_TOP: assert property (
    @(posedge clk) disable iff (!nrst)
    (masterClearPin | powerOnReset) |=> excCode == C_RESET)
    else $error("reset cause not taken first");
  AST_SSTEP: assert property (
    @(posedge clk) disable iff (!nrst)
    (singleStepEn && !debugMode && !masterClearPin && !powerOnReset)
    |=> excCode == C_SSTEP)
    else $error("single step not taken");
  AST_DBGINT: assert property (
    @(posedge clk) disable iff (!nrst)
    ((extDebugIrqIn | debugBreakRequestBit) && clearAbove[C_DBGINT])
    |=> excCode == C_DBGINT)
    else $error("debug interrupt not taken");
  AST_NMI_OVER_IRQ: assert property (
    @(posedge clk) disable iff (!nrst)
    (nmiIn && clearAbove[C_NMI])
    |=> excCode == C_NMI && excSuppressed[C_IRQ] == $past(cause[C_IRQ]))
    else $error("nmi rank wrong");
  AST_IRQ: assert property (
    @(posedge clk) disable iff (!nrst)
    (clearAbove[C_IRQ] && |(irqReq & irqMask)) |=> excCode == C_IRQ)
    else $error("interrupt not taken");
  AST_IBRK: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_IBRK] && clearAbove[C_IBRK]) |=> excCode == C_IBRK)
    else $error("instruction break not taken");
  AST_FADDR: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_FADDR] && clearAbove[C_FADDR]) |=> excCode == C_FADDR)
    else $error("fetch address error not taken");
  AST_FBUS: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_FBUS] && clearAbove[C_FBUS]) |=> excCode == C_FBUS)
    else $error("fetch bus error not taken");
  AST_DBGBP: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_DBGBP] && clearAbove[C_DBGBP]) |=> excCode == C_DBGBP)
    else $error("debug breakpoint not taken");
  AST_SYSTEM_CALL_INSTR: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_SYSTEM_CALL_INSTR] && clearAbove[C_SYSTEM_CALL_INSTR])
    |=> excCode == C_SYSTEM_CALL_INSTR)
    else $error("system call not taken");
  AST_BREAK: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_BREAK] && clearAbove[C_BREAK]) |=> excCode == C_BREAK)
    else $error("break not taken");
  AST_RESV: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_RESV] && clearAbove[C_RESV]) |=> excCode == C_RESV)
    else $error("reserved instruction not taken");
  AST_COPU: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_COPU] && clearAbove[C_COPU]) |=> excCode == C_COPU)
    else $error("coprocessor unusable not taken");
  AST_EXTU: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_EXTU] && clearAbove[C_EXTU]) |=> excCode == C_EXTU)
    else $error("extension unusable not taken");
  AST_OVF: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_OVF] && clearAbove[C_OVF]) |=> excCode == C_OVF)
    else $error("overflow not taken");
  AST_TRAP: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_TRAP] && clearAbove[C_TRAP]) |=> excCode == C_TRAP)
    else $error("trap not taken");
  AST_DADDR: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_DADDR] && clearAbove[C_DADDR]) |=> excCode == C_DADDR)
    else $error("data address break not taken");
  AST_LOAD_OVER_STORE: assert property (
    @(posedge clk) disable iff (!nrst)
    (clearAbove[C_LADDR] && cause[C_LADDR]) |=> excCode == C_LADDR)
    else $error("load error not above store");
  AST_SADDR: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_SADDR] && clearAbove[C_SADDR]) |=> excCode == C_SADDR)
    else $error("store address error not taken");
  AST_DBUS: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_DBUS] && clearAbove[C_DBUS]) |=> excCode == C_DBUS)
    else $error("data bus error not taken");
  AST_DVAL_LAST: assert property (
    @(posedge clk) disable iff (!nrst)
    (cause[C_DVAL] && clearAbove[C_DVAL])
    |=> excCode == C_DVAL && excSuppressed == '0)
    else $error("value break not lowest");
  AST_ONE_TAKEN: assert property (
    @(posedge clk) disable iff (!nrst)
    excValid |-> (excSuppressed[excCode] == 1'b0))
    else $error("winner also suppressed");
  // any pending cause must be reported, none means an idle report
  AST_VALID: assert property (
    @(posedge clk) disable iff (!nrst)
    (|cause) |=> excValid && excCode != C_NONE)
    else $error("pending cause not reported");
  AST_IDLE: assert property (
    @(posedge clk) disable iff (!nrst)
    !(|cause) |=> !excValid && excCode == C_NONE)
    else $error("report without a cause");
  // stepping is muted while the debug handler runs
  AST_STEP_MUTED: assert property (
    @(posedge clk) disable iff (!nrst)
    (debugMode && singleStepEn)
    |=> excCode != C_SSTEP && !excSuppressed[C_SSTEP])
    else $error("single step seen in debug mode");
  AST_DEBUG_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    (debugMode && !debugReturnInstr && !masterClearPin && !powerOnReset)
    |=> debugMode)
    else $error("debug mode left early");
  // a debug winner enters debug unless the return leaves it
  AST_DEBUG_ENTRY: assert property (
    @(posedge clk) disable iff (!nrst)
    ((|(cause & clearAbove & DEBUG_MASK)) &&
      !(debugMode && debugReturnInstr))
    |=> debugMode)
    else $error("debug exception did not enter debug");
  AST_DEBUG_EXIT: assert property (
    @(posedge clk) disable iff (!nrst)
    (debugMode && debugReturnInstr) |=> !debugMode)
    else $error("return did not leave debug");
  AST_RESET_RUN: assert property (
    @(posedge clk) disable iff (!nrst)
    cause[C_RESET] |=> !debugMode && !powerDown)
    else $error("reset cause did not force running");
  AST_WAIT: assert property (
    @(posedge clk) disable iff (!nrst)
    (!debugMode && !powerDown && waitInstr && !(|cause))
    |=> powerDown)
    else $error("wait did not power down");
  AST_SLEEP_WAKE: assert property (
    @(posedge clk) disable iff (!nrst)
    (powerDown && wakeEvent) |=> !powerDown)
    else $error("wake did not leave power down");

  // main scenarios
  COV_DEBUG_ENTRY: cover property (@(posedge clk) disable iff (!nrst)
    !debugMode ##1 debugMode ##[1:20] !debugMode);
  COV_SLEEP: cover property (@(posedge clk) disable iff (!nrst)
    powerDown ##1 !powerDown);
  COV_MULTI: cover property (@(posedge clk) disable iff (!nrst)
    excValid && excSuppressed != '0);
  // store break needs both compares, worth seeing on its own
  COV_STORE_BREAK: cover property (@(posedge clk) disable iff (!nrst)
    storeAddrMatch && storeDataMatch && clearAbove[C_DADDR]);
  COV_SLEEP_TO_DEBUG: cover property (@(posedge clk) disable iff (!nrst)
    powerDown ##1 debugMode);

endmodule
`default_nettype wire

// ### cep_prioritizer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module cep_prioritizer_tb_top;
  import cep_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [20:0] causeVec = 21'h0; // causes asked of the pipeline
  logic alt = 1'b0;
  logic debugReturnInstr = 1'b0;
  logic waitInstr = 1'b0;
  logic wakeEvent = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  wire logic masterClearPin, powerOnReset, singleStepEn, extDebugIrqIn;
  wire logic debugBreakRequestBit, nmiIn, instrBreakMatch, fetchBusErr;
  wire logic fetchMisaligned, fetchProtected, debugBreakpointInstr;
  wire logic systemCallInstr, breakInstr, reservedInstr, copUnusable;
  wire logic extUnusable, arithOverflow, trapTrue, loadAddrMatch;
  wire logic storeAddrMatch, storeDataMatch, loadMisaligned, dataBusErr;
  wire logic loadProtected, storeMisaligned, storeProtected, loadDataMatch;
  wire logic excValid, debugMode, powerDown;
  wire logic [7:0] irqReq, irqMask;
  wire logic [4:0] excCode;
  wire logic [20:0] excSuppressed;
  cep_pipe_model i_cep_pipe_model (.causeVec, .alt, .masterClearPin,
    .powerOnReset, .singleStepEn, .extDebugIrqIn, .debugBreakRequestBit,
    .nmiIn, .irqReq, .irqMask, .instrBreakMatch, .fetchMisaligned,
    .fetchProtected, .fetchBusErr, .debugBreakpointInstr, .systemCallInstr,
    .breakInstr, .reservedInstr, .copUnusable, .extUnusable, .arithOverflow,
    .trapTrue, .loadAddrMatch, .storeAddrMatch, .storeDataMatch,
    .loadMisaligned, .loadProtected, .storeMisaligned, .storeProtected,
    .dataBusErr, .loadDataMatch);
  cep_prioritizer i_cep_prioritizer (.clk, .nrst, .masterClearPin,
    .powerOnReset, .singleStepEn, .extDebugIrqIn, .debugBreakRequestBit,
    .nmiIn, .irqReq, .irqMask, .instrBreakMatch, .fetchMisaligned,
    .fetchProtected, .fetchBusErr, .debugBreakpointInstr, .systemCallInstr,
    .breakInstr, .reservedInstr, .copUnusable, .extUnusable, .arithOverflow,
    .trapTrue, .loadAddrMatch, .storeAddrMatch, .storeDataMatch,
    .loadMisaligned, .loadProtected, .storeMisaligned, .storeProtected,
    .dataBusErr, .loadDataMatch, .debugReturnInstr, .waitInstr, .wakeEvent,
    .excValid, .excCode, .excSuppressed, .debugMode, .powerDown);
  always #5 clk = ~clk;
  // step past an edge by the fixed drive delay
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [4:0] exp);
    check_count++;
    if (excCode !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, excCode, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // each cause raised with every lower cause pending beside it
  task automatic t_ladder(input logic a);
    logic [20:0] v;
    alt = a;
    for (int i = 0; i < CAUSE_N; i++) begin
      v = 21'h1FFFFF << i;
      causeVec = v;
      cyc();
      case (i)
        0: chk_code(C_RESET);
        1: chk_code(C_SSTEP);
        2: chk_code(C_DBGINT);
        3: chk_code(C_NMI);
        4: chk_code(C_IRQ);
        5: chk_code(C_IBRK);
        6: chk_code(C_FADDR);
        7: chk_code(C_FBUS);
        8: chk_code(C_DBGBP);
        9: chk_code(C_SYSTEM_CALL_INSTR);
        10: chk_code(C_BREAK);
        11: chk_code(C_RESV);
        12: chk_code(C_COPU);
        13: chk_code(C_EXTU);
        14: chk_code(C_OVF);
        15: chk_code(C_TRAP);
        16: chk_code(C_DADDR);
        17: chk_code(C_LADDR);
        18: chk_code(C_SADDR);
        19: chk_code(C_DBUS);
        default: chk_code(C_DVAL);
      endcase
      chk(excSuppressed, v & ~(21'h1 << i));
      causeVec = 21'h0;
      cyc();
      chk(21'(debugMode), 21'(DEBUG_MASK[i]));
      chk(21'(excValid), 21'h0);
      debugReturnInstr = 1'b1;
      cyc();
      debugReturnInstr = 1'b0;
      chk(21'(debugMode), 21'h0);
    end
  endtask
  // a step request is dropped while already in debug mode
  task automatic t_step_in_debug();
    causeVec = 21'h4;
    cyc();
    causeVec = 21'h0;
    cyc();
    causeVec = 21'h2;
    cyc();
    chk(21'(excCode), 21'(C_NONE));
    chk(21'(debugMode), 21'h1);
    causeVec = 21'h0;
    debugReturnInstr = 1'b1;
    cyc();
    debugReturnInstr = 1'b0;
  endtask
  // power down by wait, left by wake; refused beside a cause
  task automatic t_wait();
    waitInstr = 1'b1;
    cyc();
    waitInstr = 1'b0;
    chk(21'(powerDown), 21'h1);
    wakeEvent = 1'b1;
    cyc();
    wakeEvent = 1'b0;
    chk(21'(powerDown), 21'h0);
    waitInstr = 1'b1;
    causeVec = 21'h200;
    cyc();
    waitInstr = 1'b0;
    causeVec = 21'h0;
    chk(21'(powerDown), 21'h0);
  endtask
  // power down left by a debug cause; reset cause forces running
  task automatic t_sleep_exit();
    waitInstr = 1'b1;
    cyc();
    waitInstr = 1'b0;
    chk(21'(powerDown), 21'h1);
    alt = 1'b0;
    causeVec = 21'h20;
    cyc();
    causeVec = 21'h0;
    chk(21'(powerDown), 21'h0);
    chk(21'(debugMode), 21'h1);
    causeVec = 21'h1;
    cyc();
    causeVec = 21'h0;
    chk(21'(debugMode), 21'h0);
    chk_code(C_RESET);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    cyc();
    t_ladder(1'b0);
    t_ladder(1'b1);
    t_step_in_debug();
    t_wait();
    t_sleep_exit();
    test_done();
  end
  // watchdog, far beyond the roughly 140 cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
